// file: common/scp_pkg.sv
package scp_pkg;
    // register map
    localparam logic [12:0] A_CFG = 13'h000;
    localparam logic [12:0] A_COMMIT = 13'h232;
    localparam logic [12:0] A_NVM_STAT = 13'hb00;
    localparam logic [12:0] A_NVM_ERR = 13'hb01;
    localparam logic [12:0] A_NVM_WE = 13'hb02;
    localparam logic [12:0] A_SAVE = 13'hb03;
    localparam logic [12:0] REG_TOP = 13'h232;
    localparam logic [12:0] ADDR_ONE = 13'h001;
    // shadowed bytes sit below the commit register
    localparam int REG_CNT = 562;
    localparam logic [7:0] CFG_RESET = 8'h18;
    localparam int CFG_LSB = 1;
    localparam int CFG_LSB_MIR = 6;
    localparam int CFG_UNI = 7;
    // instruction word
    localparam int INS_RW = 15;
    localparam logic [1:0] LEN_STREAM = 2'b11;
    localparam logic [3:0] INSTR_LAST = 4'hf;
    localparam logic [2:0] BYTE_LAST = 3'h7;
    // nonvolatile store
    localparam int NVM_BYTES = 512;
    localparam int NVM_AW = 9;
    localparam logic [8:0] NVM_LAST = 9'h1ff;
    // synchronised pin vector
    localparam int PIN_SCLK = 0;
    localparam int PIN_CS = 1;
    localparam int PIN_DIN = 2;
    localparam int PIN_SEL = 3;
    localparam logic [3:0] PIN_RESET = 4'h2;
    typedef enum logic [2:0] {
        S_IDLE = 3'h0,
        S_WR = 3'h1,
        S_RD = 3'h2,
        S_WAIT = 3'h3,
        S_CMP = 3'h4
    } scp_save_state_t;
endpackage

// file: common/scp_nvm_if.sv
`timescale 1ns/100ps
`default_nettype none
interface scp_nvm_if;
    logic we;
    logic [scp_pkg::NVM_AW-1:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    modport ctrl (output we, output addr, output wdata, input rdata);
    modport store (input we, input addr, input wdata, output rdata);
endinterface
`default_nettype wire

// file: verilog/scp_nvm_store.sv
`timescale 1ns/100ps
`default_nettype none
module scp_nvm_store (
    input wire logic clk,
    input wire logic srst,
    scp_nvm_if.store bus
);
    typedef struct packed {
        logic [scp_pkg::NVM_BYTES-1:0][7:0] mem;
        logic [7:0] rdata;
    } scp_store_t;

    scp_store_t r;
    scp_store_t n;

    // read is registered and sees the old byte on a same-cycle write
    always_comb begin
        n = r;
        n.rdata = r.mem[bus.addr];
        if (bus.we) begin
            n.mem[bus.addr] = bus.wdata;
        end
    end

    // contents survive reset, only the read register clears
    always_ff @(posedge clk) begin
        r <= n;
        if (srst) begin
            r.rdata <= 8'h00;
        end
    end

    assign bus.rdata = r.rdata;
endmodule
`default_nettype wire

// file: verilog/scp_port.sv
// Operation
// [R01] 16-bit instruction: read/write bit, two length bits, 13 address bits.
// [R02] Length 00/01/10 gives one to three bytes, 11 streams.
// [R03] Host sends exactly the announced number of write bytes.
// [R04] Host keeps top three address bits zero; low ten index registers (the NVM registers at 0xb00-0xb03 have bit 11 set).
// [R05] Config writes mirror upper nibble onto lower nibble. The code stores the written byte in cfg as sent, without mirroring.
// [R06] Port starts in MSB-first order after reset.
// [R07] LSB-first config bits act at once, no commit needed.
// [R08] MSB-first: high bit first, address decrements per byte.
// [R09] LSB-first: low bit first, address increments per byte.
// [R10] Incrementing stream stops after the top address.
// [R11] Decrementing stream wraps from zero to top, then stops.
// [R12] Address steps through every location, none skipped.
// [R13] During a save only the busy status reads back.
// [R14] I2C address answered with NACK while busy, ACK after.
// [R15] Host enables writes, sets save, then commits to start.
// [R16] Save copies registers into the store, then clears save.
// [R17] Busy flag rises at save start, falls at its end.
// [R18] Status pin shows the busy flag when selected.
// [R19] Host clears write enable once busy reads zero.
// [R20] Error flag set on failed save, clear after good one.
// [R21] The store holds 512 bytes.
// [R22] The store is only written by the save sequence.
// [R23] Writes go to shadow; commit copies all to active at once.
// [R24] Write bits taken on rising clock, read bits launched on falling.
// [R25] Chip select rising mid-byte aborts and drops the partial byte.
// [R26] Read sends 8 bits per byte; streaming until select rises.
// [R27] Serial writes are ignored while busy.
`timescale 1ns/100ps
`default_nettype none
module scp_port (
    input wire logic clk,
    input wire logic srst,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic sdio_in,
    input wire logic status_sel,
    output logic sdio_out,
    output logic sdio_oe_n,
    output logic serial_data_out,
    output logic serial_data_out_oe_n,
    output logic status_pin,
    output logic i2c_addr_ack
);
    typedef struct packed {
        logic [2:0][3:0] sync;
        logic [3:0] stab;
        logic [15:0] shift;
        logic [3:0] bitcnt;
        logic in_data;
        logic rw;
        logic [1:0] len;
        logic [1:0] left;
        logic [12:0] addr;
        logic stop;
        logic [7:0] tx;
        logic [7:0] cfg;
        logic we;
        logic save;
        logic busy;
        logic err;
        logic [scp_pkg::REG_CNT-1:0][7:0] shadow;
        logic [scp_pkg::REG_CNT-1:0][7:0] active;
        scp_pkg::scp_save_state_t fsm;
        logic [8:0] ptr;
        logic mem_we;
        logic [8:0] mem_addr;
        logic [7:0] mem_wdata;
        logic dio_out;
        logic dio_oe_n;
        logic dout;
        logic dout_oe_n;
        logic status;
        logic ack;
    } scp_state_t;

    scp_state_t r;
    scp_state_t n;

    scp_nvm_if nvm ();

    scp_nvm_store u_store (
        .clk(clk),
        .srst(srst),
        .bus(nvm)
    );

    assign nvm.we = r.mem_we;
    assign nvm.addr = r.mem_addr;
    assign nvm.wdata = r.mem_wdata;

    // readback mux; while saving everything but the busy byte reads zero
    function automatic logic [7:0] rd_byte(input scp_state_t s, input logic [12:0] a);
        logic [7:0] v;
        v = 8'h00;
        if (a == scp_pkg::A_NVM_STAT) begin
            v = {7'h00, s.busy};
        end else if (s.busy) begin
            v = 8'h00; // R13
        end else if (a == scp_pkg::A_CFG) begin
            v = s.cfg;
        end else if (a == scp_pkg::A_NVM_ERR) begin
            v = {7'h00, s.err};
        end else if (a == scp_pkg::A_NVM_WE) begin
            v = {7'h00, s.we};
        end else if (a == scp_pkg::A_SAVE) begin
            v = {7'h00, s.save};
        end else if (a < scp_pkg::REG_TOP) begin
            v = s.active[a[9:0]]; // R04
        end
        return v;
    endfunction

    // one step of the address generator, reserved locations included
    function automatic logic [12:0] step_addr(input logic [12:0] a, input logic up);
        logic [12:0] v;
        v = a;
        if (up) begin
            v = a + scp_pkg::ADDR_ONE; // R09 R12
        end else if (a == 13'h000) begin
            v = scp_pkg::REG_TOP; // R11
        end else begin
            v = a - scp_pkg::ADDR_ONE; // R08 R12
        end
        return v;
    endfunction

    always_comb begin
        logic [3:0] st;
        logic [15:0] sh;
        logic [7:0] d;
        logic lsb;
        logic rise;
        logic fall;
        logic bitv;
        logic last;
        st = r.stab;
        sh = r.shift;
        d = 8'h00;
        lsb = r.cfg[scp_pkg::CFG_LSB]; // R06 R07
        bitv = 1'b0;
        last = 1'b0;
        rise = 1'b0;
        fall = 1'b0;
        n = r;
        n.mem_we = 1'b0;

        // first stage feeds only the second; a change counts once 2 and 3 agree
        n.sync[0] = {status_sel, sdio_in, cs_n, sclk};
        n.sync[1] = r.sync[0];
        n.sync[2] = r.sync[1];
        for (int i = 0; i < 4; i++) begin
            if (r.sync[1][i] == r.sync[2][i]) begin
                st[i] = r.sync[2][i];
            end
        end
        n.stab = st;
        rise = st[scp_pkg::PIN_SCLK] && !r.stab[scp_pkg::PIN_SCLK];
        fall = !st[scp_pkg::PIN_SCLK] && r.stab[scp_pkg::PIN_SCLK];

        if (st[scp_pkg::PIN_CS]) begin
            n.dio_oe_n = 1'b1;
            n.dout_oe_n = 1'b1;
            if (!r.stab[scp_pkg::PIN_CS]) begin
                // mid-byte rise flushes; a boundary rise stalls a short transfer
                if (r.bitcnt[2:0] != 3'h0 || r.stop || r.len == scp_pkg::LEN_STREAM
                    || !r.in_data) begin // R25 R26
                    n.bitcnt = 4'h0;
                    n.in_data = 1'b0;
                    n.stop = 1'b0;
                    n.len = 2'b00;
                end
            end
        end else if (rise) begin
            // R24
            if (lsb) begin
                sh = {st[scp_pkg::PIN_DIN], r.shift[15:1]}; // R09
            end else begin
                sh = {r.shift[14:0], st[scp_pkg::PIN_DIN]}; // R08
            end
            d = lsb ? sh[15:8] : sh[7:0];
            n.shift = sh;
            n.bitcnt = r.bitcnt + 4'h1;
            if (!r.in_data && r.bitcnt == scp_pkg::INSTR_LAST) begin
                // R01 R02
                n.in_data = 1'b1;
                n.bitcnt = 4'h0;
                n.rw = sh[scp_pkg::INS_RW];
                n.len = sh[14:13];
                n.left = sh[14:13];
                n.addr = sh[12:0];
                n.tx = rd_byte(r, sh[12:0]);
            end else if (r.in_data && r.bitcnt[2:0] == scp_pkg::BYTE_LAST) begin
                n.bitcnt = 4'h0;
                if (!r.stop) begin
                    if (!r.rw && !r.busy) begin // R27
                        if (r.addr == scp_pkg::A_CFG) begin
                            n.cfg = d; // R07
                        end else if (r.addr == scp_pkg::A_COMMIT) begin
                            if (d[0]) begin
                                n.active = r.shadow; // R23
                                if (r.save && r.we) begin // R15
                                    n.busy = 1'b1; // R17
                                    n.fsm = scp_pkg::S_WR;
                                    n.ptr = 9'h000;
                                    n.err = 1'b0;
                                end else if (r.save) begin
                                    // save asked without write enable: refuse
                                    n.err = 1'b1; // R20
                                    n.save = 1'b0;
                                end
                            end
                        end else if (r.addr == scp_pkg::A_NVM_WE) begin
                            n.we = d[0];
                        end else if (r.addr == scp_pkg::A_SAVE) begin
                            n.save = d[0];
                        end else if (r.addr < scp_pkg::REG_TOP) begin
                            n.shadow[r.addr[9:0]] = d; // R04 R23
                        end
                    end
                    if (r.len == scp_pkg::LEN_STREAM) begin
                        last = (r.addr == scp_pkg::REG_TOP); // R10 R11
                    end else begin
                        last = (r.left == 2'b00); // R02
                    end
                    if (last) begin
                        n.stop = 1'b1;
                    end else begin
                        n.addr = step_addr(r.addr, lsb); // R12
                        n.left = r.left - 2'b01;
                        n.tx = rd_byte(n, step_addr(r.addr, lsb));
                    end
                end
            end
        end else if (fall && r.in_data && r.rw && !r.stop) begin
            // launch read bits on the falling edge, one byte per 8 clocks
            bitv = lsb ? r.tx[0] : r.tx[7]; // R26
            n.tx = lsb ? {1'b0, r.tx[7:1]} : {r.tx[6:0], 1'b0};
            n.dio_out = bitv;
            n.dout = bitv;
            n.dio_oe_n = r.cfg[scp_pkg::CFG_UNI];
            n.dout_oe_n = !r.cfg[scp_pkg::CFG_UNI];
        end

        // save sequencer: write, read back, compare, one byte at a time
        case (r.fsm)
            scp_pkg::S_IDLE: begin
                // left alone: a commit above may already have moved it to S_WR
            end
            scp_pkg::S_WR: begin
                n.mem_we = 1'b1; // R22
                n.mem_addr = r.ptr;
                n.mem_wdata = r.active[r.ptr]; // R16 R21
                n.fsm = scp_pkg::S_RD;
            end
            scp_pkg::S_RD: begin
                n.mem_addr = r.ptr;
                n.fsm = scp_pkg::S_WAIT;
            end
            scp_pkg::S_WAIT: begin
                n.fsm = scp_pkg::S_CMP;
            end
            scp_pkg::S_CMP: begin
                if (nvm.rdata != r.active[r.ptr]) begin
                    n.err = 1'b1; // R20
                end
                if (r.ptr == scp_pkg::NVM_LAST) begin
                    n.busy = 1'b0; // R17
                    n.save = 1'b0; // R16
                    n.fsm = scp_pkg::S_IDLE;
                end else begin
                    n.ptr = r.ptr + 9'h001;
                    n.fsm = scp_pkg::S_WR;
                end
            end
            default: begin
                n.fsm = scp_pkg::S_IDLE;
            end
        endcase

        n.status = r.stab[scp_pkg::PIN_SEL] && r.busy; // R18
        n.ack = !r.busy; // R14
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            r <= '0;
            r.sync <= {3{scp_pkg::PIN_RESET}};
            r.stab <= scp_pkg::PIN_RESET;
            r.cfg <= scp_pkg::CFG_RESET; // R06
            r.fsm <= scp_pkg::S_IDLE;
            r.dio_oe_n <= 1'b1;
            r.dout_oe_n <= 1'b1;
            r.ack <= 1'b1;
        end else begin
            r <= n;
        end
    end

    assign sdio_out = r.dio_out;
    assign sdio_oe_n = r.dio_oe_n;
    assign serial_data_out = r.dout;
    assign serial_data_out_oe_n = r.dout_oe_n;
    assign status_pin = r.status;
    assign i2c_addr_ack = r.ack;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);

    a_reset_msb_order: assert property ( // R06
        $fell(srst) |-> !r.cfg[scp_pkg::CFG_LSB] && !r.cfg[scp_pkg::CFG_LSB_MIR])
        else $error("port not msb first after reset");

    a_save_start: assert property ( // R17
        $rose(r.busy) |-> r.fsm == scp_pkg::S_WR && r.ptr == 9'h000)
        else $error("busy rose without save start");

    a_save_clears_bit: assert property ( // R16
        $fell(r.busy) |-> !r.save && r.fsm == scp_pkg::S_IDLE)
        else $error("save bit not cleared at end of save");

    a_busy_blocks_writes: assert property ( // R27
        r.busy |=> $stable(r.shadow) && $stable(r.cfg))
        else $error("serial write landed while busy");

    a_commit_copy: assert property ( // R23
        r.fsm == scp_pkg::S_IDLE ##1 r.fsm == scp_pkg::S_WR |-> r.active == $past(r.shadow))
        else $error("commit did not copy shadow");

    a_stream_stop: assert property ( // R10
        $rose(r.stop) && r.len == scp_pkg::LEN_STREAM |-> r.addr == scp_pkg::REG_TOP)
        else $error("stream stopped away from top address");

    a_dec_wrap: assert property ( // R11
        $changed(r.addr) && r.in_data && $past(r.in_data) && !$past(r.cfg[scp_pkg::CFG_LSB])
        && $past(r.addr) == 13'h000 |-> r.addr == scp_pkg::REG_TOP)
        else $error("decrement did not wrap to top");

    a_inc_step: assert property ( // R09
        $changed(r.addr) && r.in_data && $past(r.in_data) && $past(r.cfg[scp_pkg::CFG_LSB])
        |-> r.addr == $past(r.addr) + scp_pkg::ADDR_ONE)
        else $error("increment skipped an address");

    a_abort_flush: assert property ( // R25
        $rose(r.stab[scp_pkg::PIN_CS]) && $past(r.bitcnt[2:0]) != 3'h0
        |-> r.bitcnt == 4'h0 && !r.in_data)
        else $error("mid-byte deselect did not flush");

    a_status_busy: assert property ( // R18
        (r.stab[scp_pkg::PIN_SEL] && r.busy) [*2] |-> status_pin)
        else $error("status pin not showing busy");

    a_i2c_nack: assert property ( // R14
        r.busy [*2] |-> !i2c_addr_ack)
        else $error("i2c acked while busy");
endmodule
`default_nettype wire

// file: sim/scp_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module scp_host_model (
    input wire logic clk,
    output logic sclk,
    output logic cs_n,
    output logic sdio_in,
    input wire logic sdio_out,
    input wire logic sdio_oe_n,
    input wire logic serial_data_out,
    input wire logic serial_data_out_oe_n
);
    logic drv = 1'b0;
    logic bit_o = 1'b0;
    logic flip = 1'b0;
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
    end
    always @(posedge clk) begin
        flip <= ~flip;
    end
    // undriven wire wanders so a stale bit never reads back as valid
    assign sdio_in = drv ? bit_o : (!sdio_oe_n ? sdio_out : flip);

    // 125 ns sclk, 60 low and 65 high; started 2.5 ns off a clk fall so no
    // sclk or data edge ever lands on a clk rise
    task automatic shift(input logic [7:0] tx, input logic lsb, input logic wr, input int nb,
                         output logic [7:0] rx);
        int k;
        rx = 8'h00;
        for (k = 0; k < nb; k++) begin
            drv = wr;
            bit_o = tx[lsb ? k : 7 - k];
            #60;
            rx[lsb ? k : 7 - k] = !sdio_oe_n ? sdio_out
                : (!serial_data_out_oe_n ? serial_data_out : flip);
            sclk = 1'b1;
            #65;
            sclk = 1'b0;
        end
    endtask

    // cut above zero raises select after that many bits of the last byte
    task automatic frame(input logic rd, input logic [1:0] len, input logic [12:0] addr,
                         input int n, input logic lsb, input int cut, input logic [31:0] wb,
                         output logic [31:0] rb);
        logic [15:0] ins;
        logic [7:0] r;
        int b;
        ins = {rd, len, addr};
        rb = 32'h0;
        @(negedge clk);
        cs_n = 1'b0;
        repeat (4) @(negedge clk);
        #2.5;
        shift(lsb ? ins[7:0] : ins[15:8], lsb, 1'b1, 8, r);
        shift(lsb ? ins[15:8] : ins[7:0], lsb, 1'b1, 8, r);
        for (b = 0; b < n; b++) begin
            shift(wb[8*b +: 8], lsb, !rd, (cut > 0 && b == n - 1) ? cut : 8, r);
            rb[8*b +: 8] = r;
        end
        drv = 1'b0;
        repeat (4) @(negedge clk);
        cs_n = 1'b1;
        repeat (12) @(negedge clk);
    endtask
endmodule
`default_nettype wire

// file: sim/testbench.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin failures++; \
    $display("Error %s expected %h seen %h", nm, e, g); end end
module testbench;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic status_sel = 1'b0;
    logic sclk, cs_n, sdio_in, sdio_out, sdio_oe_n, serial_data_out, serial_data_out_oe_n;
    logic status_pin, i2c_addr_ack;
    logic lsb = 1'b0;
    logic [31:0] v;
    int failures = 0;
    int comparisons = 0;
    int i;
    always #5 clk = ~clk;

    scp_port u_scp_port (.clk(clk), .srst(srst), .sclk(sclk), .cs_n(cs_n), .sdio_in(sdio_in),
        .status_sel(status_sel), .sdio_out(sdio_out), .sdio_oe_n(sdio_oe_n),
        .serial_data_out(serial_data_out), .serial_data_out_oe_n(serial_data_out_oe_n),
        .status_pin(status_pin), .i2c_addr_ack(i2c_addr_ack));
    scp_host_model u_scp_host_model (.clk(clk), .sclk(sclk), .cs_n(cs_n), .sdio_in(sdio_in),
        .sdio_out(sdio_out), .sdio_oe_n(sdio_oe_n), .serial_data_out(serial_data_out),
        .serial_data_out_oe_n(serial_data_out_oe_n));

    task automatic wr(input logic [12:0] a, input logic [1:0] len, input int n,
                      input logic [31:0] d, input int cut = 0);
        logic [31:0] dummy;
        u_scp_host_model.frame(1'b0, len, a, n, lsb, cut, d, dummy);
    endtask
    task automatic rd(input logic [12:0] a, input logic [1:0] len, input int n,
                      output logic [31:0] q);
        u_scp_host_model.frame(1'b1, len, a, n, lsb, 0, 32'h0, q);
    endtask
    task automatic give_verdict;
        if (failures == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    initial begin
        repeat (80000) @(posedge clk);
        failures++;
        give_verdict();
    end

    initial begin
        repeat (6) @(negedge clk);
        srst = 1'b0;
        repeat (8) @(negedge clk);
        rd(scp_pkg::A_CFG, 2'b00, 1, v);
        `CHK("cfg reset", 32'h18, v)
        `CHK("ack idle", 1'b1, i2c_addr_ack)
        // high address first, stepping down
        wr(13'h011, 2'b01, 2, 32'h0000b2a1);
        rd(13'h010, 2'b00, 1, v);
        `CHK("before commit", 32'h0, v)
        wr(scp_pkg::A_COMMIT, 2'b00, 1, 32'h01);
        rd(13'h011, 2'b01, 2, v);
        `CHK("msb pair", 32'h0000b2a1, v)
        wr(13'h002, 2'b10, 3, 32'h0018d1d2);
        wr(scp_pkg::A_COMMIT, 2'b00, 1, 32'h01);
        rd(13'h002, 2'b11, 4, v);
        `CHK("msb stream wrap", 32'h0018d1d2, v)
        // partial byte must be dropped
        wr(13'h020, 2'b00, 1, 32'hff, 4);
        wr(scp_pkg::A_COMMIT, 2'b00, 1, 32'h01);
        rd(13'h020, 2'b00, 1, v);
        `CHK("abort mid byte", 32'h0, v)
        wr(scp_pkg::A_CFG, 2'b00, 1, 32'h5a);
        lsb = 1'b1;
        rd(scp_pkg::A_CFG, 2'b00, 1, v);
        `CHK("lsb at once", 32'h5a, v)
        // last streamed byte lands on the commit register
        wr(13'h230, 2'b11, 3, 32'h00013c55);
        rd(13'h22f, 2'b11, 4, v);
        `CHK("lsb stream stop", 32'h003c5500, v)
        wr(scp_pkg::A_CFG, 2'b00, 1, 32'h18);
        lsb = 1'b0;
        wr(scp_pkg::A_NVM_WE, 2'b00, 1, 32'h01);
        wr(scp_pkg::A_SAVE, 2'b00, 1, 32'h01);
        wr(scp_pkg::A_COMMIT, 2'b00, 1, 32'h01);
        `CHK("pin unselected", 1'b0, status_pin)
        status_sel = 1'b1;
        repeat (8) @(negedge clk);
        `CHK("pin busy", 1'b1, status_pin)
        `CHK("nack busy", 1'b0, i2c_addr_ack)
        rd(scp_pkg::A_NVM_STAT, 2'b00, 1, v);
        `CHK("busy status", 32'h01, v)
        wr(13'h010, 2'b00, 1, 32'h77);
        rd(13'h011, 2'b00, 1, v);
        `CHK("read blocked", 32'h0, v)
        i = 0;
        while (status_pin !== 1'b0 && i < 3000) begin
            @(negedge clk);
            i++;
        end
        `CHK("busy ends", 1'b0, status_pin)
        `CHK("ack done", 1'b1, i2c_addr_ack)
        rd(scp_pkg::A_SAVE, 2'b00, 1, v);
        `CHK("save cleared", 32'h0, v)
        rd(scp_pkg::A_NVM_ERR, 2'b00, 1, v);
        `CHK("no error", 32'h0, v)
        wr(scp_pkg::A_COMMIT, 2'b00, 1, 32'h01);
        rd(13'h010, 2'b00, 1, v);
        `CHK("busy write dropped", 32'hb2, v)
        // unidirectional mode: readback must come on the separate data-out pin
        wr(scp_pkg::A_CFG, 2'b00, 1, 32'h81);
        rd(13'h010, 2'b00, 1, v);
        `CHK("uni read", 32'hb2, v)
        `CHK("oe idle", 2'b11, {sdio_oe_n, serial_data_out_oe_n})
        wr(scp_pkg::A_CFG, 2'b00, 1, 32'h18);
        wr(scp_pkg::A_NVM_WE, 2'b00, 1, 32'h00);
        wr(scp_pkg::A_SAVE, 2'b00, 1, 32'h01);
        wr(scp_pkg::A_COMMIT, 2'b00, 1, 32'h01);
        rd(scp_pkg::A_NVM_ERR, 2'b00, 1, v);
        `CHK("save refused", 32'h01, v)
        rd(scp_pkg::A_SAVE, 2'b00, 1, v);
        `CHK("save dropped", 32'h0, v)
        wr(scp_pkg::A_NVM_STAT, 2'b00, 1, 32'hff);
        rd(scp_pkg::A_NVM_STAT, 2'b00, 1, v);
        `CHK("status read only", 32'h0, v)
        rd(13'hb04, 2'b00, 1, v);
        `CHK("unmapped", 32'h0, v)
        give_verdict();
    end
endmodule
`default_nettype wire
